// *** verilog/wsd_defines.vh ***
// Purpose: constants for the wake, status and debounce unit
// Assumes: included by the unit's design file and by the bench; guarded
// Notes:   addresses are five-bit serial command addresses
`ifndef WSD_DEFINES_VH
`define WSD_DEFINES_VH
// ****************************************
// register addresses and reset values
// ****************************************
`define WSD_ADDR_CTRL3     5'h02
`define WSD_ADDR_CTRL4     5'h03
`define WSD_ADDR_CTRL6     5'h05
`define WSD_ADDR_STATUS    5'h08
`define WSD_CTRL6_RESET    8'h9c
`define WSD_CTRL3_RESET    2'h3
`define WSD_CTRL3_SUPPLY   1
`define WSD_CTRL3_CLKON    0
`define WSD_CTRL4_LIM_SCALE 0
// ****************************************
// status register layout
// ****************************************
`define WSD_ST_AUX         0
`define WSD_ST_LOWB        1
`define WSD_ST_PWRON       2
`define WSD_ST_KEY_LSB     3
`define WSD_ST_KEY_MSB     7
// ****************************************
// serial command types (upper three bits)
// ****************************************
`define WSD_CMD_READ       3'h2
`define WSD_CMD_WRITE      3'h3
`define WSD_CMD_OFF        3'h4
`define WSD_CMD_DELIRQ     3'h5
// ****************************************
// timing
// ****************************************
`define WSD_DCLK_DIV       8'd16
`define WSD_DEBOUNCE_TICKS 8195
`define WSD_BAUD_R0        5'd8
`define WSD_BAUD_R1        5'd4
`define WSD_BAUD_R2        5'd2
`define WSD_BAUD_R3        5'd1
`endif

// *** verilog/wsd_unit.v ***
// Purpose: wake, key debounce, status flags and config for a transceiver
// Assumes: serial port pins and analog comparators are asynchronous inputs
// Notes:   serial clock is oversampled by clk; keep it at least 8x slower
`timescale 1ns/1ns
`include "wsd_defines.vh"

module wsd_unit #(
    parameter DEBOUNCE_COUNT = `WSD_DEBOUNCE_TICKS
) (
    // clock and reset
    input  wire       clk,
    input  wire       resetn,
    // serial port from host
    input  wire       spi_cs,
    input  wire       spi_sck,
    input  wire       spi_sdi,
    output reg        spi_sdo,
    output reg        spi_sdo_oe,
    // key and wake pins
    input  wire [4:0] key_input_n,
    input  wire       wake_pin,
    input  wire       aux_supply_pin,
    // analog status
    input  wire       supply_low,
    input  wire       supply_recovered,
    input  wire       supply_good,
    input  wire       osc_settled,
    input  wire       regulator_switch,
    // interval timing
    input  wire       interval_start,
    output reg        xdclk_tick,
    output reg        interval_max_hit,
    // power and host control
    output reg        irq,
    output reg        host_resetn,
    output reg        ext_supply_enable,
    output reg        clk_out_enable
);
    localparam ST_OFF  = 3'b001;
    localparam ST_WAKE = 3'b010;
    localparam ST_ACT  = 3'b100;

    // ****************************************
    // input synchronisers
    // ****************************************
    reg  [4:0] key_s1_reg;
    reg  [4:0] key_s2_reg;
    reg  [4:0] key_last_reg;
    reg  [4:0] pin_s1_reg;
    reg  [4:0] pin_s2_reg;
    reg  [4:0] pin_last_reg;
    reg  [2:0] spi_s1_reg;
    reg  [2:0] spi_s2_reg;
    reg        sck_last_reg;
    wire [4:0] pins_in = {regulator_switch, supply_recovered, supply_low,
                          aux_supply_pin, wake_pin};
    wire       wake_s  = pin_s2_reg[0];
    wire       aux_s   = pin_s2_reg[1];
    wire       low_s   = pin_s2_reg[2];
    wire       rec_s   = pin_s2_reg[3];
    wire       reg_s   = pin_s2_reg[4];
    wire       cs_s    = spi_s2_reg[0];
    wire       sck_s   = spi_s2_reg[1];
    wire       sdi_s   = spi_s2_reg[2];

    // one flop pair per key, all in one loop
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_key
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    key_s1_reg[gi] <= 1'b1;
                    key_s2_reg[gi] <= 1'b1;
                end else begin
                    key_s1_reg[gi] <= key_input_n[gi];
                    key_s2_reg[gi] <= key_s1_reg[gi];
                end
            end
        end
    endgenerate

    // other pins; first stage feeds only the second
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_s1_reg <= 5'h00;
            pin_s2_reg <= 5'h00;
            spi_s1_reg <= 3'h0;
            spi_s2_reg <= 3'h0;
        end else begin
            pin_s1_reg <= pins_in;
            pin_s2_reg <= pin_s1_reg;
            spi_s1_reg <= {spi_sdi, spi_sck, spi_cs};
            spi_s2_reg <= spi_s1_reg;
        end
    end

    wire [4:0] key_evt   = key_s2_reg ^ key_last_reg;
    wire [4:0] key_fall  = key_last_reg & ~key_s2_reg;
    wire       wake_rise = wake_s & ~pin_last_reg[0];
    wire       aux_rise  = aux_s & ~pin_last_reg[1];
    wire       reg_rise  = reg_s & ~pin_last_reg[4];
    wire       sck_rise  = sck_s & ~sck_last_reg;
    wire       sck_fall  = ~sck_s & sck_last_reg;

    // ****************************************
    // digital and extended bit clocks
    // ****************************************
    reg  [7:0]  dclk_cnt_reg;
    reg         dclk_tick_reg;
    reg  [4:0]  xd_cnt_reg;
    reg  [5:0]  iv_cnt_reg;
    reg         iv_run_reg;
    reg  [7:0]  ctrl6_reg;
    reg  [1:0]  ctrl3_reg;
    reg         limit_scale_reg;
    reg  [4:0]  xd_mult;

    // range code to period multiple, doubled when extended
    always @* begin
        case (ctrl6_reg[7:6])
            2'b00:   xd_mult = `WSD_BAUD_R0;
            2'b01:   xd_mult = `WSD_BAUD_R1;
            2'b10:   xd_mult = `WSD_BAUD_R2;
            default: xd_mult = `WSD_BAUD_R3;
        endcase
        if (limit_scale_reg)
            xd_mult = {xd_mult[3:0], 1'b0};
    end

    // divider chain and max-interval timer
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dclk_cnt_reg     <= 8'h00;
            dclk_tick_reg    <= 1'b0;
            xd_cnt_reg       <= 5'h00;
            xdclk_tick       <= 1'b0;
            iv_cnt_reg       <= 6'h00;
            iv_run_reg       <= 1'b0;
            interval_max_hit <= 1'b0;
        end else begin
            dclk_tick_reg    <= (dclk_cnt_reg == `WSD_DCLK_DIV - 8'd1);
            dclk_cnt_reg     <= (dclk_cnt_reg == `WSD_DCLK_DIV - 8'd1) ? 8'h00
                                : dclk_cnt_reg + 8'd1;
            xdclk_tick       <= 1'b0;
            interval_max_hit <= 1'b0;
            if (dclk_tick_reg) begin
                if (xd_cnt_reg >= xd_mult - 5'd1) begin
                    xd_cnt_reg <= 5'h00;
                    xdclk_tick <= 1'b1;
                end else
                    xd_cnt_reg <= xd_cnt_reg + 5'd1;
            end
            if (interval_start) begin
                iv_cnt_reg <= 6'h00;
                iv_run_reg <= 1'b1;
            end else if (iv_run_reg && xdclk_tick) begin
                if (iv_cnt_reg + 6'd2 >= ctrl6_reg[5:0]) begin
                    iv_run_reg       <= 1'b0;
                    interval_max_hit <= 1'b1;
                end else
                    iv_cnt_reg <= iv_cnt_reg + 6'd1;
            end
        end
    end

    // ****************************************
    // serial port
    // ****************************************
    reg  [2:0] bit_cnt_reg;
    reg  [7:0] rx_shift_reg;
    reg  [7:0] tx_shift_reg;
    reg        first_reg;
    reg  [2:0] cmd_reg;
    reg  [4:0] addr_reg;
    reg  [7:0] status_reg;
    reg  [7:0] rd_data;
    wire [7:0] rx_byte  = {rx_shift_reg[6:0], sdi_s};
    wire       byte_end = cs_s & host_resetn & sck_rise & (bit_cnt_reg == 3'd7);
    wire       cmd_end  = byte_end & first_reg;
    wire       dat_end  = byte_end & ~first_reg;
    wire [2:0] new_cmd  = rx_byte[7:5];
    wire [4:0] rd_addr  = cmd_end ? rx_byte[4:0] : addr_reg + 5'd1;
    wire       do_read  = (cmd_end & new_cmd == `WSD_CMD_READ) |
                          (dat_end & cmd_reg == `WSD_CMD_READ);
    wire       wr_en    = dat_end & (cmd_reg == `WSD_CMD_WRITE);
    wire       stat_rd  = do_read & (rd_addr == `WSD_ADDR_STATUS);
    wire       del_irq  = cmd_end & (new_cmd == `WSD_CMD_DELIRQ);
    wire       off_cmd  = cmd_end & (new_cmd == `WSD_CMD_OFF);

    // read mux; unmapped addresses read zero
    always @* begin
        case (rd_addr)
            `WSD_ADDR_CTRL3:  rd_data = {6'h00, ctrl3_reg};
            `WSD_ADDR_CTRL4:  rd_data = {7'h00, limit_scale_reg};
            `WSD_ADDR_CTRL6:  rd_data = ctrl6_reg;
            `WSD_ADDR_STATUS: rd_data = status_reg;
            default:          rd_data = 8'h00;
        endcase
    end

    // mode 0: sample on rising edge, shift out on falling, msb first
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sck_last_reg <= 1'b0;
            bit_cnt_reg  <= 3'h0;
            rx_shift_reg <= 8'h00;
            tx_shift_reg <= 8'h00;
            first_reg    <= 1'b1;
            cmd_reg      <= 3'h0;
            addr_reg     <= 5'h00;
            spi_sdo      <= 1'b0;
            spi_sdo_oe   <= 1'b0;
        end else begin
            sck_last_reg <= sck_s;
            spi_sdo_oe   <= cs_s & host_resetn;
            spi_sdo      <= tx_shift_reg[7];
            if (!cs_s || !host_resetn) begin
                // low select holds the port in reset; no traffic during host reset
                bit_cnt_reg  <= 3'h0;
                first_reg    <= 1'b1;
                tx_shift_reg <= 8'h00; // buffer count, no buffer here
            end else if (sck_rise) begin
                rx_shift_reg <= rx_byte;
                bit_cnt_reg  <= bit_cnt_reg + 3'd1;
                if (bit_cnt_reg == 3'd7) begin
                    first_reg <= 1'b0;
                    if (first_reg) begin
                        cmd_reg  <= new_cmd;
                        addr_reg <= rx_byte[4:0];
                    end else
                        addr_reg <= addr_reg + 5'd1;
                    // read returns data; other commands echo the byte
                    tx_shift_reg <= do_read ? rd_data : rx_byte;
                end
            end else if (sck_fall && bit_cnt_reg != 3'h0)
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl6_reg <= `WSD_CTRL6_RESET;
            ctrl3_reg <= `WSD_CTRL3_RESET;
            limit_scale_reg <= 1'b0;
        end else if (wr_en) begin
            case (addr_reg)
                `WSD_ADDR_CTRL6: ctrl6_reg <= rx_byte;
                `WSD_ADDR_CTRL3: ctrl3_reg <= rx_byte[1:0];
                `WSD_ADDR_CTRL4: limit_scale_reg <= rx_byte[`WSD_CTRL4_LIM_SCALE];
                default:         ctrl6_reg <= ctrl6_reg;
            endcase
        end
    end

    // ****************************************
    // power state, wake causes, debounce
    // ****************************************
    reg  [2:0]  state_reg;
    reg  [4:0]  cause_key_reg;
    reg         cause_pwr_reg;
    reg         cause_aux_reg;
    reg         deb_run_reg;
    reg  [4:0]  deb_key_reg;
    reg  [13:0] deb_cnt_reg;
    reg         deb_done_reg;
    wire        active   = (state_reg == ST_ACT);
    wire        deb_hit  = deb_run_reg & dclk_tick_reg &
                           (deb_cnt_reg == DEBOUNCE_COUNT - 1);
    wire        settle   = (state_reg == ST_WAKE) & osc_settled & supply_good;
    wire        can_off  = wake_s == 1'b0 && key_s2_reg == 5'h1f;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg     <= ST_OFF;
            key_last_reg  <= 5'h1f;
            pin_last_reg  <= 5'h00;
            cause_key_reg <= 5'h00;
            cause_pwr_reg <= 1'b0;
            cause_aux_reg <= 1'b0;
            deb_run_reg   <= 1'b0;
            deb_key_reg   <= 5'h00;
            deb_cnt_reg   <= 14'h0000;
            deb_done_reg  <= 1'b0;
        end else begin
            key_last_reg <= key_s2_reg;
            pin_last_reg <= pin_s2_reg;
            deb_done_reg <= deb_hit;
            case (state_reg)
                ST_OFF: begin
                    cause_key_reg <= key_fall;
                    cause_pwr_reg <= wake_rise;
                    cause_aux_reg <= aux_s;
                    // the wake pin going low never forces off
                    if (|key_fall || wake_rise || aux_s)
                        state_reg <= ST_WAKE;
                end
                ST_WAKE: begin
                    if (settle)
                        state_reg <= ST_ACT;
                end
                ST_ACT: begin
                    if (off_cmd && can_off && !cause_aux_reg)
                        state_reg <= ST_OFF;
                end
                default: state_reg <= ST_OFF;
            endcase
            // debounce runs only in the active state, not while off or waking
            if (!active) begin
                deb_run_reg <= 1'b0;
            end else if (|key_evt) begin
                if (deb_run_reg && (key_evt & ~deb_key_reg) == 5'h00)
                    deb_run_reg <= 1'b0;
                else begin
                    deb_run_reg <= 1'b1;
                    deb_key_reg <= key_evt;
                    deb_cnt_reg <= 14'h0000;
                end
            end else if (deb_hit)
                deb_run_reg <= 1'b0;
            else if (deb_run_reg && dclk_tick_reg)
                deb_cnt_reg <= deb_cnt_reg + 14'd1;
        end
    end

    // ****************************************
    // status flags and interrupt
    // ****************************************
    wire pwr_set  = (settle & cause_pwr_reg) | (active & wake_rise);
    wire aux_set  = (settle & cause_aux_reg) |
                    (active & (aux_rise | reg_rise));
    wire key_set  = (settle & |cause_key_reg) | deb_done_reg;
    wire pwr_new  = pwr_set & ~status_reg[`WSD_ST_PWRON];
    wire aux_new  = aux_set & ~status_reg[`WSD_ST_AUX];
    wire force_on = status_reg[`WSD_ST_PWRON] | deb_run_reg;

    // a new event in the clearing cycle wins over the clear
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_reg        <= 8'h00;
            irq               <= 1'b0;
            host_resetn       <= 1'b0;
            ext_supply_enable <= 1'b0;
            clk_out_enable    <= 1'b0;
        end else begin
            if (settle)
                status_reg[`WSD_ST_KEY_MSB:`WSD_ST_KEY_LSB] <=
                    status_reg[`WSD_ST_KEY_MSB:`WSD_ST_KEY_LSB] | cause_key_reg;
            else if (deb_done_reg)
                status_reg[`WSD_ST_KEY_MSB:`WSD_ST_KEY_LSB] <= ~key_s2_reg;
            if (pwr_set)
                status_reg[`WSD_ST_PWRON] <= 1'b1;
            else if (stat_rd)
                status_reg[`WSD_ST_PWRON] <= 1'b0;
            if (aux_set)
                status_reg[`WSD_ST_AUX] <= 1'b1;
            else if (stat_rd)
                status_reg[`WSD_ST_AUX] <= 1'b0;
            if (low_s && state_reg != ST_OFF)
                status_reg[`WSD_ST_LOWB] <= 1'b1;
            else if (stat_rd && rec_s)
                status_reg[`WSD_ST_LOWB] <= 1'b0;
            if (pwr_new || aux_new || key_set)
                irq <= 1'b1;
            else if (stat_rd || del_irq)
                irq <= 1'b0;
            // host held in reset until supply good and oscillator settled
            host_resetn <= active;
            ext_supply_enable <= (state_reg != ST_OFF) &
                                 (ctrl3_reg[`WSD_CTRL3_SUPPLY] | force_on |
                                  ~active);
            clk_out_enable <= osc_settled & (state_reg != ST_OFF) &
                              (ctrl3_reg[`WSD_CTRL3_CLKON] | force_on |
                               ~active);
        end
    end

endmodule // wsd_unit

// *** testbench/wsd_unit_chk.sv ***
// Purpose: port assertions for the wake, status and debounce unit
// Assumes: bound to every wsd_unit instance
// Notes:   windows allow for the two-flop input synchronisers
`timescale 1ns/1ns
module wsd_unit_chk #(
    parameter DEBOUNCE_COUNT = 8195
) (
    // clock and reset
    input logic       clk,
    input logic       resetn,
    // serial port
    input logic       spi_cs,
    input logic       spi_sck,
    input logic       spi_sdi,
    input logic       spi_sdo,
    input logic       spi_sdo_oe,
    // pins and analog status
    input logic [4:0] key_input_n,
    input logic       wake_pin,
    input logic       aux_supply_pin,
    input logic       supply_low,
    input logic       supply_recovered,
    input logic       supply_good,
    input logic       osc_settled,
    input logic       regulator_switch,
    // interval timing
    input logic       interval_start,
    input logic       xdclk_tick,
    input logic       interval_max_hit,
    // host side outputs
    input logic       irq,
    input logic       host_resetn,
    input logic       ext_supply_enable,
    input logic       clk_out_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ****************************************
    // assertions
    // ****************************************
    // wake edge in active mode must force both enables on
    a_wake_enables: assert property ($rose(wake_pin) && host_resetn |-> ##[1:16]
        ext_supply_enable && clk_out_enable) else $error("wake edge left enables off");
    a_key_enables: assert property ($changed(key_input_n) && host_resetn |-> ##[1:8]
        ext_supply_enable && clk_out_enable) else $error("key event left enables off");
    a_reset_release: assert property ($rose(host_resetn) |->
        supply_good && osc_settled) else $error("host reset released too early");
    a_irq_clear_cause: assert property ($fell(irq) |-> $past(spi_cs))
        else $error("irq dropped without host access");
    a_sdo_release: assert property ($fell(spi_cs) |-> ##[1:6] !spi_sdo_oe)
        else $error("sdo still driven after deselect");
    a_sdo_off_reset: assert property (!host_resetn && !$past(host_resetn) |-> !spi_sdo_oe)
        else $error("sdo driven while host held in reset");
    a_sdo_drive: assert property ($rose(spi_cs) && host_resetn |-> ##[2:6] spi_sdo_oe)
        else $error("sdo not driven after select");
    a_max_not_early: assert property (interval_start |=> !interval_max_hit [*8])
        else $error("max interval hit right after start");
    a_max_pulse: assert property (interval_max_hit |=> !interval_max_hit)
        else $error("max interval strobe longer than one cycle");
    a_tick_pulse: assert property (xdclk_tick |=> !xdclk_tick)
        else $error("extended bit clock tick too long");
    // main scenarios seen
    c_irq_clear: cover property ($fell(irq));
    c_wake_done: cover property ($rose(host_resetn));
    c_max_hit: cover property (interval_max_hit);
endmodule // wsd_unit_chk

bind wsd_unit wsd_unit_chk #(.DEBOUNCE_COUNT(DEBOUNCE_COUNT)) i_wsd_unit_chk (.clk, .resetn,
    .spi_cs, .spi_sck, .spi_sdi, .spi_sdo, .spi_sdo_oe, .key_input_n, .wake_pin,
    .aux_supply_pin, .supply_low, .supply_recovered, .supply_good, .osc_settled,
    .regulator_switch, .interval_start, .xdclk_tick, .interval_max_hit, .irq,
    .host_resetn, .ext_supply_enable, .clk_out_enable);

// *** testbench/wsd_host_model.sv ***
// Purpose: host model driving the four-wire serial port
// Assumes: sck high and low ten clk cycles each, 80 ns per bit
// Notes:   sdi is inverted between frames so stale data never matches
`timescale 1ns/1ns
module wsd_host_model (
    // clock
    input  wire clk,
    // serial lines
    output reg  spi_cs,
    output reg  spi_sck,
    output reg  spi_sdi,
    input  wire spi_sdo
);
    reg [7:0] rx;
    integer   i;
    // idle: deselected, clock parked low
    initial begin
        spi_cs = 1'b0;
        spi_sck = 1'b0;
        spi_sdi = 1'b0;
    end
    // ****************************************
    // frame: select, command, optional data byte
    // ****************************************
    task frame(input [7:0] cmd_byte, input [7:0] dat, input two);
        begin
            spi_cs <= 1'b1;
            repeat (8) @(posedge clk);
            for (i = 15; i >= 0; i = i - 1) begin
                if (i > 7 || two) begin
                    spi_sdi <= (i > 7) ? cmd_byte[i - 8] : dat[i];
                    repeat (10) @(posedge clk);
                    spi_sck <= 1'b1;
                    rx[i % 8] = spi_sdo;
                    repeat (10) @(posedge clk);
                    spi_sck <= 1'b0;
                end
            end
            repeat (10) @(posedge clk);
            spi_cs <= 1'b0;
            spi_sdi <= ~spi_sdi;
            repeat (10) @(posedge clk);
        end
    endtask
endmodule // wsd_host_model

// *** testbench/wake_status_debounce_unit_tb.sv ***
// Purpose: self-checking bench for the wake, status and debounce unit
// Assumes: debounce count cut to 20 ticks; host model makes serial traffic
// Notes:   outputs are read at the clock edge, before its updates land
`timescale 1ns/1ns
`include "wsd_defines.vh"
module wake_status_debounce_unit_tb;
    reg        clk = 1'b0;
    reg        resetn = 1'b0;
    reg  [4:0] key_input_n = 5'h1f;
    reg        wake_pin = 1'b0;
    reg        aux_supply_pin = 1'b0;
    reg        supply_low = 1'b0;
    reg        supply_recovered = 1'b0;
    reg        supply_good = 1'b0;
    reg        osc_settled = 1'b0;
    reg        regulator_switch = 1'b0;
    reg        interval_start = 1'b0;
    wire       spi_cs, spi_sck, spi_sdi, spi_sdo, spi_sdo_oe, xdclk_tick, interval_max_hit;
    wire       irq, host_resetn, ext_supply_enable, clk_out_enable;
    integer    miscompares = 0;
    integer    checked = 0;
    integer    cycles = 0;
    integer    c;
    integer    n;
    // released sdo shows a toggling level, never the last bit
    wire       sdo_line = spi_sdo_oe ? spi_sdo : cycles[0];
    wsd_unit #(.DEBOUNCE_COUNT(20)) i_wsd_unit (.clk, .resetn, .spi_cs, .spi_sck,
        .spi_sdi, .spi_sdo, .spi_sdo_oe, .key_input_n, .wake_pin, .aux_supply_pin,
        .supply_low, .supply_recovered, .supply_good, .osc_settled, .regulator_switch,
        .interval_start, .xdclk_tick, .interval_max_hit, .irq, .host_resetn,
        .ext_supply_enable, .clk_out_enable);
    wsd_host_model i_wsd_host_model (.clk, .spi_cs, .spi_sck, .spi_sdi, .spi_sdo(sdo_line));
    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares = miscompares + 1;
            final_report;
        end
    end
    // ****************************************
    // access and compare tasks
    // ****************************************
    task check_bit(input got, input exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
            end
        end
    endtask
    task rd_chk(input [4:0] a, input [7:0] exp);
        begin
            i_wsd_host_model.frame({`WSD_CMD_READ, a}, 8'h00, 1'b1);
            checked = checked + 1;
            if (i_wsd_host_model.rx !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0t reg %h read %h", $time, a, i_wsd_host_model.rx);
            end
        end
    endtask
    task wr(input [4:0] a, input [7:0] v);
        i_wsd_host_model.frame({`WSD_CMD_WRITE, a}, v, 1'b1);
    endtask
    task wait_irq;
        begin
            n = 0;
            while (irq !== 1'b1 && n < 500) begin
                @(posedge clk);
                n = n + 1;
            end
            check_bit(irq, 1'b1);
        end
    endtask
    task tick_gap;
        begin
            while (xdclk_tick !== 1'b1) @(posedge clk);
            @(posedge clk);
            n = 1;
            while (xdclk_tick !== 1'b1 && n < 600) begin
                @(posedge clk);
                n = n + 1;
            end
        end
    endtask
    task final_report;
        begin
            $display("checked %0d miscompares %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk);
        check_bit(host_resetn, 1'b0);
        resetn <= 1'b1;
        repeat (20) @(posedge clk);
        wake_pin <= 1'b1;
        repeat (10) @(posedge clk);
        check_bit(host_resetn, 1'b0);
        check_bit(ext_supply_enable, 1'b1);
        supply_good <= 1'b1;
        osc_settled <= 1'b1;
        wait_irq;
        repeat (4) @(posedge clk);
        check_bit(host_resetn, 1'b1);
        rd_chk(`WSD_ADDR_STATUS, 8'h04);
        check_bit(irq, 1'b0);
        rd_chk(`WSD_ADDR_STATUS, 8'h00);
        wake_pin <= 1'b0;
        rd_chk(`WSD_ADDR_CTRL6, {2'b10, 6'd28});
        check_bit(host_resetn, 1'b1);
        wr(`WSD_ADDR_CTRL3, 8'h00);
        wake_pin <= 1'b1;
        wait_irq;
        i_wsd_host_model.frame({`WSD_CMD_DELIRQ, 5'h00}, 8'h00, 1'b0);
        check_bit(irq, 1'b0);
        check_bit(ext_supply_enable & clk_out_enable, 1'b1);
        wake_pin <= 1'b0;
        repeat (20) @(posedge clk);
        wake_pin <= 1'b1;
        repeat (50) @(posedge clk);
        check_bit(irq, 1'b0);
        rd_chk(`WSD_ADDR_STATUS, 8'h04);
        check_bit(ext_supply_enable, 1'b0);
        // each rate code, then the doubled scale
        for (c = 0; c < 5; c = c + 1) begin
            if (c == 4) wr(`WSD_ADDR_CTRL4, 8'h01);
            wr(`WSD_ADDR_CTRL6, {c[1:0], 6'd12});
            tick_gap;
            tick_gap;
            check_bit(n == (8 >> c[1:0]) * 16 * (c == 4 ? 2 : 1), 1'b1);
        end
        wr(`WSD_ADDR_CTRL6, {2'b11, 6'd12});
        interval_start <= 1'b1;
        @(posedge clk);
        interval_start <= 1'b0;
        n = 0;
        while (interval_max_hit !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n = n + 1;
        end
        check_bit(n > 320 && n < 400, 1'b1);
        wr(`WSD_ADDR_CTRL4, 8'h00);
        rd_chk(5'h1f, 8'h00);
        // debounce: complete, same-key stop, other-key restart
        key_input_n[0] <= 1'b0;
        repeat (200) @(posedge clk);
        check_bit(irq, 1'b0);
        check_bit(ext_supply_enable & clk_out_enable, 1'b1);
        wait_irq;
        rd_chk(`WSD_ADDR_STATUS, 8'h08);
        key_input_n[0] <= 1'b1;
        repeat (100) @(posedge clk);
        key_input_n[0] <= 1'b0;
        repeat (600) @(posedge clk);
        check_bit(irq, 1'b0);
        key_input_n[1] <= 1'b0;
        repeat (200) @(posedge clk);
        key_input_n[2] <= 1'b0;
        repeat (200) @(posedge clk);
        check_bit(irq, 1'b0);
        wait_irq;
        wr(`WSD_ADDR_STATUS, 8'hff);
        rd_chk(`WSD_ADDR_STATUS, 8'h38);
        // low supply holds until recovered and read
        supply_low <= 1'b1;
        repeat (20) @(posedge clk);
        supply_low <= 1'b0;
        rd_chk(`WSD_ADDR_STATUS, 8'h3a);
        supply_recovered <= 1'b1;
        rd_chk(`WSD_ADDR_STATUS, 8'h3a);
        rd_chk(`WSD_ADDR_STATUS, 8'h38);
        regulator_switch <= 1'b1;
        wait_irq;
        rd_chk(`WSD_ADDR_STATUS, 8'h39);
        rd_chk(`WSD_ADDR_STATUS, 8'h38);
        // release keys and wake pin, go off, wake by key, then aux edge
        key_input_n <= 5'h1f;
        wake_pin <= 1'b0;
        wait_irq;
        rd_chk(`WSD_ADDR_STATUS, 8'h00);
        i_wsd_host_model.frame({`WSD_CMD_OFF, 5'h00}, 8'h00, 1'b0);
        check_bit(host_resetn | ext_supply_enable | clk_out_enable, 1'b0);
        key_input_n[3] <= 1'b0;
        wait_irq;
        rd_chk(`WSD_ADDR_STATUS, 8'h40);
        aux_supply_pin <= 1'b1;
        wait_irq;
        rd_chk(`WSD_ADDR_STATUS, 8'h41);
        final_report;
    end
endmodule // wake_status_debounce_unit_tb
